// [rtl/mas_top.v]
// media auto-sense control: switch control register, sensing, interrupt
// assumes an axi4-lite master on aclk and media status pins from outside
//
// How it works
// - a set sense enable bit turns on monitoring of the unused medium.
// - in serdes or sgmii mode the copper receiver idle detector is armed.
// - in copper mode the serdes idle detector is armed if source is clear.
// - energy on the unused medium sets the cause bit and drops the enable.
// - while config is set both the phy and the serdes stay powered.
// - while config is set no energy may set the cause bit.
// - the source bit picks the external pin or serdes idle exit as energy.
// - the same chosen source is the serdes signal detect for link up.
// - bit 9 reads back the serdes signal detect from the chosen source.
// - bit 10 reads back the copper phy signal detect.
// - after reset the source bit loads from bit 15 of this port's nvm word.
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/10ps
`include "mas_defs.vh"

module mas_top
#(
  parameter ADDR_WIDTH = 12,
  parameter PORT_INDEX = 0
)
(
  input wire aclk,
  input wire aresetn,
  // axi4-lite slave
  input wire [ADDR_WIDTH-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [ADDR_WIDTH-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // nvm word loader, same clock
  input wire nvm_word_valid,
  input wire [7:0] nvm_word_addr,
  input wire [15:0] nvm_word_data,
  // media status pins, asynchronous
  input wire copper_rx_energy,
  input wire serdes_rx_energy,
  input wire ext_signal_detect,
  // media controls
  output reg copper_idle_detect_en,
  output reg serdes_idle_detect_en,
  output reg copper_power_on,
  output reg serdes_power_on,
  output reg serdes_signal_detect,
  output reg irq
);

  ////////////////////////////////////////////////////////////////////////////
  // address decode, shared by the read and write paths

  function [2:0] reg_select;
    input [ADDR_WIDTH-1:0] addr;
    begin
      case (addr)
        `MAS_ADDR_SWITCH_CTL: reg_select = `MAS_SEL_SWITCH_CTL;
        `MAS_ADDR_CAUSE: reg_select = `MAS_SEL_CAUSE;
        `MAS_ADDR_CAUSE_CLR: reg_select = `MAS_SEL_CAUSE_CLR;
        `MAS_ADDR_IRQ_ENABLE: reg_select = `MAS_SEL_IRQ_ENABLE;
        `MAS_ADDR_MEDIA_SEL: reg_select = `MAS_SEL_MEDIA_SEL;
        default: reg_select = `MAS_SEL_NONE;
      endcase
    end
  endfunction

  localparam [7:0] NVM_WORD =
    (PORT_INDEX == 0) ? `MAS_NVM_WORD_PORT0 : `MAS_NVM_WORD_PORT1;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  wire [2:0] pins_sync;
  wire copper_energy;
  wire serdes_idle_exit;
  wire ext_sd;

  mas_sync
  #(
    .WIDTH(3)
  )
  u_pin_sync
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in({ext_signal_detect, serdes_rx_energy, copper_rx_energy}),
    .sync_out(pins_sync)
  );

  assign copper_energy = pins_sync[0];
  assign serdes_idle_exit = pins_sync[1];
  assign ext_sd = pins_sync[2];

  ////////////////////////////////////////////////////////////////////////////
  // register state

  reg sense_en_q;
  reg sense_en_d;
  reg sense_conf_q;
  reg energy_src_q;
  reg energy_src_d;
  reg serdes_mode_q;
  reg cause_q;
  reg cause_d;
  reg irq_enable_q;

  // write channel holding state
  reg [ADDR_WIDTH-1:0] aw_addr_q;
  reg aw_held_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  reg w_held_q;

  wire aw_take;
  wire w_take;
  wire wr_fire;
  wire [2:0] wr_sel;
  wire wr_lane0;
  wire ar_take;
  wire [2:0] rd_sel;

  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take = s_axi_wvalid & s_axi_wready;
  // the write lands once both halves are held and no response is pending
  assign wr_fire = aw_held_q & w_held_q & ~s_axi_bvalid;
  assign wr_sel = reg_select(aw_addr_q);
  assign wr_lane0 = w_strb_q[0];
  assign ar_take = s_axi_arvalid & s_axi_arready;
  assign rd_sel = reg_select(s_axi_araddr);

  ////////////////////////////////////////////////////////////////////////////
  // sensing

  wire serdes_sd_sel;
  wire other_energy;
  wire sense_hit;
  wire ctl_write;
  wire clr_write;

  // one chosen source serves both energy sensing and link up
  assign serdes_sd_sel = energy_src_q ? ext_sd : serdes_idle_exit;

  // energy on whichever medium is not carrying the link
  assign other_energy = serdes_mode_q ? copper_energy : serdes_sd_sel;

  // a level test, so energy already present when enabled also hits
  assign sense_hit = sense_en_q & ~sense_conf_q & other_energy;

  assign ctl_write = wr_fire & wr_lane0 & (wr_sel == `MAS_SEL_SWITCH_CTL);
  assign clr_write = wr_fire & wr_lane0 & (wr_sel == `MAS_SEL_CAUSE_CLR);

  always @*
  begin
    sense_en_d = sense_en_q;
    if (sense_hit)
    begin
      sense_en_d = 1'b0;
    end
    // a software write in the same cycle wins; a re-enable re-senses at once
    if (ctl_write)
    begin
      sense_en_d = w_data_q[`MAS_BIT_SENSE_EN];
    end
  end

  always @*
  begin
    cause_d = cause_q;
    if (clr_write && w_data_q[`MAS_BIT_OTHER_MEDIA])
    begin
      cause_d = 1'b0;
    end
    // set wins over a clear landing in the same cycle
    if (sense_hit)
    begin
      cause_d = 1'b1;
    end
  end

  always @*
  begin
    energy_src_d = energy_src_q;
    if (nvm_word_valid && (nvm_word_addr == NVM_WORD))
    begin
      energy_src_d = nvm_word_data[`MAS_NVM_BIT_ENERGY_SRC];
    end
    if (ctl_write)
    begin
      energy_src_d = w_data_q[`MAS_BIT_ENERGY_SRC];
    end
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sense_en_q <= `MAS_RST_SENSE_EN;
      sense_conf_q <= `MAS_RST_SENSE_CONF;
      energy_src_q <= `MAS_RST_ENERGY_SRC;
      serdes_mode_q <= `MAS_RST_SERDES_MODE;
      cause_q <= 1'b0;
      irq_enable_q <= `MAS_RST_IRQ_ENABLE;
    end
    else
    begin
      sense_en_q <= sense_en_d;
      energy_src_q <= energy_src_d;
      cause_q <= cause_d;
      if (ctl_write)
      begin
        sense_conf_q <= w_data_q[`MAS_BIT_SENSE_CONF];
      end
      if (wr_fire && wr_lane0 && (wr_sel == `MAS_SEL_IRQ_ENABLE))
      begin
        irq_enable_q <= w_data_q[`MAS_BIT_OTHER_MEDIA];
      end
      if (wr_fire && wr_lane0 && (wr_sel == `MAS_SEL_MEDIA_SEL))
      begin
        serdes_mode_q <= w_data_q[`MAS_BIT_SERDES_MODE];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // media control outputs

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      copper_idle_detect_en <= 1'b0;
      serdes_idle_detect_en <= 1'b0;
      copper_power_on <= 1'b0;
      serdes_power_on <= 1'b0;
      serdes_signal_detect <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      copper_idle_detect_en <= sense_en_q & serdes_mode_q;
      // with the external pin as source the serdes detector is not needed
      serdes_idle_detect_en <= sense_en_q & ~serdes_mode_q
                               & ~energy_src_q;
      // config keeps both media alive while software prepares them
      copper_power_on <= ~serdes_mode_q | sense_conf_q
                         | (sense_en_q & serdes_mode_q);
      serdes_power_on <= serdes_mode_q | sense_conf_q
                         | (sense_en_q & ~serdes_mode_q);
      serdes_signal_detect <= serdes_sd_sel;
      irq <= cause_d & irq_enable_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite write path

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_addr_q <= {ADDR_WIDTH{1'b0}};
      aw_held_q <= 1'b0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      w_held_q <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `MAS_RESP_OKAY;
    end
    else
    begin
      if (aw_take)
      begin
        aw_addr_q <= s_axi_awaddr;
        aw_held_q <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      else if (wr_fire)
      begin
        aw_held_q <= 1'b0;
        s_axi_awready <= 1'b1;
      end
      else
      begin
        s_axi_awready <= ~aw_held_q;
      end
      if (w_take)
      begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
        w_held_q <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      else if (wr_fire)
      begin
        w_held_q <= 1'b0;
        s_axi_wready <= 1'b1;
      end
      else
      begin
        s_axi_wready <= ~w_held_q;
      end
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        if (wr_sel == `MAS_SEL_NONE)
        begin
          s_axi_bresp <= `MAS_RESP_SLVERR;
        end
        else
        begin
          s_axi_bresp <= `MAS_RESP_OKAY;
        end
      end
      else if (s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite read path

  reg [31:0] rd_word;

  // unlisted bits stay zero, so reserved fields read as zero
  always @*
  begin
    rd_word = 32'h00000000;
    case (rd_sel)
      `MAS_SEL_SWITCH_CTL:
      begin
        rd_word[`MAS_BIT_SENSE_EN] = sense_en_q;
        rd_word[`MAS_BIT_SENSE_CONF] = sense_conf_q;
        rd_word[`MAS_BIT_ENERGY_SRC] = energy_src_q;
        rd_word[`MAS_BIT_SERDES_SD] = serdes_sd_sel;
        rd_word[`MAS_BIT_COPPER_SD] = copper_energy;
      end
      `MAS_SEL_CAUSE:
      begin
        rd_word[`MAS_BIT_OTHER_MEDIA] = cause_q;
      end
      `MAS_SEL_IRQ_ENABLE:
      begin
        rd_word[`MAS_BIT_OTHER_MEDIA] = irq_enable_q;
      end
      `MAS_SEL_MEDIA_SEL:
      begin
        rd_word[`MAS_BIT_SERDES_MODE] = serdes_mode_q;
      end
      default:
      begin
        rd_word = 32'h00000000;
      end
    endcase
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `MAS_RESP_OKAY;
    end
    else
    begin
      if (ar_take)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        if (rd_sel == `MAS_SEL_NONE)
        begin
          s_axi_rresp <= `MAS_RESP_SLVERR;
        end
        else
        begin
          s_axi_rresp <= `MAS_RESP_OKAY;
        end
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
      else
      begin
        s_axi_arready <= ~s_axi_rvalid;
      end
    end
  end

endmodule // mas_top

// [rtl/mas_defs.vh]
// constants for the media auto-sense control block
// assumes a 32-bit register bus with byte addresses and a 16-bit nvm word
`ifndef MAS_DEFS_VH
`define MAS_DEFS_VH

// register byte offsets
`define MAS_ADDR_SWITCH_CTL 12'h034
`define MAS_ADDR_CAUSE 12'h040
`define MAS_ADDR_CAUSE_CLR 12'h044
`define MAS_ADDR_IRQ_ENABLE 12'h048
`define MAS_ADDR_MEDIA_SEL 12'h04C

// register select codes from the address decoder
`define MAS_SEL_NONE 3'h0
`define MAS_SEL_SWITCH_CTL 3'h1
`define MAS_SEL_CAUSE 3'h2
`define MAS_SEL_CAUSE_CLR 3'h3
`define MAS_SEL_IRQ_ENABLE 3'h4
`define MAS_SEL_MEDIA_SEL 3'h5

// media switch control fields
`define MAS_BIT_SENSE_EN 0
`define MAS_BIT_SENSE_CONF 1
`define MAS_BIT_ENERGY_SRC 2
`define MAS_BIT_SERDES_SD 9
`define MAS_BIT_COPPER_SD 10

// cause, clear and enable layout
`define MAS_BIT_OTHER_MEDIA 0

// media select: 1 = serdes or sgmii, 0 = internal copper phy
`define MAS_BIT_SERDES_MODE 0

// reset values
`define MAS_RST_SENSE_EN 1'b0
`define MAS_RST_SENSE_CONF 1'b0
`define MAS_RST_ENERGY_SRC 1'b0
`define MAS_RST_SERDES_MODE 1'b0
`define MAS_RST_IRQ_ENABLE 1'b0

// nvm words holding the energy source default, per port
`define MAS_NVM_WORD_PORT0 8'h24
`define MAS_NVM_WORD_PORT1 8'h14
`define MAS_NVM_BIT_ENERGY_SRC 15

// axi responses
`define MAS_RESP_OKAY 2'h0
`define MAS_RESP_SLVERR 2'h2

// synchroniser depth
`define MAS_SYNC_STAGES 2

`endif

// [rtl/mas_sync.v]
// two flip-flop synchroniser for a group of independent level inputs
// assumes each bit is a slow level; bits are not coherent with each other
`timescale 1ns/10ps
module mas_sync
#(
  parameter WIDTH = 3
)
(
  input wire aclk,
  input wire aresetn,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;

  // the first stage feeds the second stage only
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_q <= {WIDTH{1'b0}};
      sync_q <= {WIDTH{1'b0}};
    end
    else
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule // mas_sync

// [bench/mas_top_assertions.sv]
// port checks for the media auto-sense control block
// assumes binding into mas_top; one clock, sync active-low reset
`timescale 1ns/10ps
module mas_top_chk
(
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire copper_idle_detect_en,
  input wire serdes_idle_detect_en,
  input wire copper_power_on,
  input wire serdes_power_on,
  input wire irq
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////
  AST_BHOLD: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped early");
  AST_BLAT: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write answer late");
  AST_RHOLD: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  AST_RLAT: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_EXCL: assert property (
    !(copper_idle_detect_en && serdes_idle_detect_en))
    else $error("both idle detectors armed");
  AST_ARMPWR: assert property (
    copper_idle_detect_en || serdes_idle_detect_en
    |-> copper_power_on && serdes_power_on) else $error("armed unpowered");
  AST_PWR_ANY: assert property (
    $past(aresetn) |-> copper_power_on || serdes_power_on)
    else $error("active medium unpowered");
  AST_RST: assert property (
    $rose(aresetn) |-> !irq && !copper_idle_detect_en
    && !serdes_idle_detect_en && !s_axi_bvalid) else $error("bad reset");
  cover property ($rose(irq));
  cover property ($rose(copper_idle_detect_en));
  cover property ($rose(serdes_idle_detect_en));
endmodule // mas_top_chk

bind mas_top mas_top_chk i_chk
(
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .copper_idle_detect_en(copper_idle_detect_en),
  .serdes_idle_detect_en(serdes_idle_detect_en),
  .copper_power_on(copper_power_on), .serdes_power_on(serdes_power_on),
  .irq(irq)
);

// [bench/mas_media_model.sv]
// copper phy and serdes receivers as seen by the control block
// assumes the bench asks for energy; an unpowered receiver shows none
`timescale 1ns/10ps
module mas_media_model
(
  input wire aclk,
  input wire cu_req,
  input wire sd_req,
  input wire ext_req,
  input wire copper_power_on,
  input wire serdes_power_on,
  output logic copper_rx_energy = 1'b0,
  output logic serdes_rx_energy = 1'b0,
  output logic ext_signal_detect = 1'b0
);
  always @(posedge aclk)
  begin
    copper_rx_energy <= cu_req && copper_power_on;
    serdes_rx_energy <= sd_req && serdes_power_on;
    // the external pin comes from the optics, not gated by our power
    ext_signal_detect <= ext_req;
  end
endmodule // mas_media_model

// [bench/media_autosense_switch_control_tb_top.sv]
// bench: axi register traffic and media energy against a reference model
// assumes mas_top with PORT_INDEX 0 and the media model beside it
`timescale 1ns/10ps
`include "mas_defs.vh"
module media_autosense_switch_control_tb_top;
  logic aclk, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, nv = 1'b0;
  logic cu_req = 1'b0, sd_req = 1'b0, ext_req = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, d;
  logic [3:0] wstrb = 4'h0;
  logic [7:0] na = 8'h00;
  logic [15:0] nd = 16'h0000;
  logic [1:0] r;
  wire awready, wready, bvalid, arready, rvalid, cu_p, sd_p, ext_p;
  wire ci_en, si_en, cu_pw, sd_pw, sd_det, irq;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  integer n_fail = 0, total_checks = 0, seed = 32'h07CD;
  integer en = 0, conf = 0, src = 0, mode = 0, cause = 0, ien = 0, k, h;
  mas_top i_dut
  (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .nvm_word_valid(nv),
    .nvm_word_addr(na), .nvm_word_data(nd), .copper_rx_energy(cu_p),
    .serdes_rx_energy(sd_p), .ext_signal_detect(ext_p),
    .copper_idle_detect_en(ci_en), .serdes_idle_detect_en(si_en),
    .copper_power_on(cu_pw), .serdes_power_on(sd_pw),
    .serdes_signal_detect(sd_det), .irq(irq)
  );
  mas_media_model i_med
  (
    .aclk(aclk), .cu_req(cu_req), .sd_req(sd_req), .ext_req(ext_req),
    .copper_power_on(cu_pw), .serdes_power_on(sd_pw),
    .copper_rx_energy(cu_p), .serdes_rx_energy(sd_p),
    .ext_signal_detect(ext_p)
  );
  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  ////////////////////////////////////////////////////////////////////////
  task give_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input [31:0] seen, input [31:0] exp, input string nm);
    total_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input [11:0] a, input [31:0] v, input [3:0] s);
    logic aw, w;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    aw = 1'b1;
    w = 1'b1;
    while (aw || w)
    begin
      @(posedge aclk);
      aw = aw && !awready;
      w = w && !wready;
      awvalid <= aw;
      wvalid <= w;
    end
    bready <= 1'b1;
    do @(posedge aclk); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask
  task rd(input [11:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge aclk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  function logic [31:0] ctl();
    ctl = en | conf << 1 | src << 2 | (src ? ext_p : sd_p) << 9 | cu_p << 10;
  endfunction
  // reserved and read-only bits get random data; reserved bits must read back zero, bits 9 and 10 the detects
  task put(input integer e, input integer c);
    en = e;
    conf = c;
    wr(`MAS_ADDR_SWITCH_CTL, $random(seed) & 32'hFFFFFFF8 | src << 2
      | c << 1 | e, 4'hF);
  endtask
  // energy on the unused medium; in serdes mode the pins that cannot hit get noise
  task on(input logic v);
    cu_req <= mode && v;
    ext_req <= mode ? 1'($random(seed)) : src && v;
    sd_req <= mode ? 1'($random(seed)) : !src && v;
  endtask
  task settle;
    @(posedge aclk);
    h = en && !conf && (mode ? cu_req : src ? ext_req : sd_req);
    repeat (10) @(posedge aclk);
    if (h)
    begin
      cause = 1;
      en = 0;
    end
  endtask
  task look;
    rd(`MAS_ADDR_SWITCH_CTL);
    chk(d, ctl(), "ctl");
    rd(`MAS_ADDR_CAUSE);
    chk(d, cause, "cause");
    chk(irq, cause & ien, "irq");
  endtask
  task clr;
    on(1'b0);
    wr(`MAS_ADDR_CAUSE_CLR, 32'h1, 4'hF);
    cause = 0;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    give_verdict;
  end
  initial
  begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    look();
    @(posedge aclk);
    nv <= 1'b1;
    na <= `MAS_NVM_WORD_PORT0;
    nd <= 16'h8000;
    @(posedge aclk);
    // the other port's word must not reload the source bit
    na <= `MAS_NVM_WORD_PORT1;
    nd <= 16'h0000;
    @(posedge aclk);
    nv <= 1'b0;
    src = 1;
    look();
    wr(12'h03C, 32'h1, 4'hF);
    chk(r, `MAS_RESP_SLVERR, "wresp");
    rd(12'h03C);
    chk(r, `MAS_RESP_SLVERR, "rresp");
    wr(`MAS_ADDR_SWITCH_CTL, 32'h3, 4'hE);
    look();
    ien = 1;
    wr(`MAS_ADDR_IRQ_ENABLE, 32'h1, 4'hF);
    for (k = 0; k < 4; k++)
    begin
      mode = k % 2;
      src = k / 2;
      wr(`MAS_ADDR_MEDIA_SEL, mode, 4'hF);
      put(1, 1);
      on(1'b1);
      settle;
      look();
      put(0, 1);
      settle;
      chk({cu_pw, sd_pw}, 2'b11, "power");
      put(1, 0);
      settle;
      look();
      ien = 0;
      wr(`MAS_ADDR_IRQ_ENABLE, 32'h0, 4'hF);
      look();
      ien = 1;
      wr(`MAS_ADDR_IRQ_ENABLE, 32'h1, 4'hF);
      clr;
      put(1, 0);
      settle;
      chk({ci_en, si_en}, mode * 2 + (!mode && !src), "arm");
      chk({cu_pw, sd_pw}, 2'b11, "pwr_arm");
      look();
      on(1'b1);
      settle;
      look();
      chk(sd_det, src ? ext_p : sd_p, "sdet");
      chk({cu_pw, sd_pw}, mode ? 2'b01 : 2'b10, "pwr_idle");
      clr;
    end
    give_verdict;
  end
endmodule // media_autosense_switch_control_tb_top
